// [verilog/sram4_host.sv]
// Host controller driving a 256 x 4 static RAM through its pins.
`timescale 1ns/1ps
module sram4_host
	import sram4_pkg::*;
#(
	parameter int unsigned ACC_CYC = SRAM4_ACC_CYC,
	parameter int unsigned AW_CYC  = SRAM4_AW_CYC,
	parameter int unsigned WP_CYC  = SRAM4_WP_CYC,
	parameter int unsigned WR_CYC  = SRAM4_WR_CYC
)
(
	// Clock and reset.
	input  wire logic                    ref_clk_i,
	input  wire logic                    reset_i,
	// User request port.
	input  wire logic                    req_valid_i,
	input  wire logic                    req_write_i,
	input  wire logic [SRAM4_ADDR_W-1:0] req_addr_i,
	input  wire logic [SRAM4_DATA_W-1:0] req_wdata_i,
	output logic                         req_ready_o,
	// User answer port.
	output logic                         rsp_valid_o,
	output logic [SRAM4_DATA_W-1:0]      rsp_rdata_o,
	// Device pins.
	output logic [SRAM4_ADDR_W-1:0]      word_select_lines_o,
	output logic [SRAM4_DATA_W-1:0]      write_data_lines_o,
	output logic                         select_low_active_n_o,
	output logic                         select_high_active_o,
	output logic                         write_strobe_n_o,
	output logic                         output_blank_o,
	input  wire logic [SRAM4_DATA_W-1:0] read_data_lines_i
);

	// =========================================================================
	// Storage for the current access
	sram4_state_t            state_ff;
	sram4_state_t            nxt_state;
	logic [SRAM4_CNT_W-1:0]  cnt_ff;
	logic [SRAM4_ADDR_W-1:0] addr_ff;
	logic [SRAM4_DATA_W-1:0] wdata_ff;
	logic                    cnt_done;
	logic                    take;

	sram4_pins_if pins_bus();

	assign req_ready_o = (state_ff == SRAM4_IDLE);
	assign take        = req_valid_i & req_ready_o;
	assign cnt_done    = (cnt_ff == '0);

	// =========================================================================
	// State sequencing
	// Each phase lasts its counted cycles; the pin driver adds one cycle of delay
	// to every pin, equally, so relative timing holds.
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			SRAM4_IDLE: begin
				if (take) begin
					nxt_state = req_write_i ? SRAM4_WSET : SRAM4_RSET;
				end
			end
			SRAM4_RSET: nxt_state = SRAM4_RACC;
			SRAM4_RACC: begin
				if (cnt_done) begin
					nxt_state = SRAM4_IDLE;
				end
			end
			SRAM4_WSET: begin
				if (cnt_done) begin
					nxt_state = SRAM4_WPUL;
				end
			end
			SRAM4_WPUL: begin
				if (cnt_done) begin
					nxt_state = SRAM4_WREC;
				end
			end
			SRAM4_WREC: begin
				if (cnt_done) begin
					nxt_state = SRAM4_IDLE;
				end
			end
			default: nxt_state = SRAM4_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			state_ff <= SRAM4_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// =========================================================================
	// Phase counter
	// Loaded with length minus one on entry to each write phase, and with the full ACC_CYC for the read access phase.
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			cnt_ff <= '0;
		end else if (state_ff != nxt_state) begin
			unique case (nxt_state)
				SRAM4_RACC: cnt_ff <= SRAM4_CNT_W'(ACC_CYC);
				SRAM4_WSET: cnt_ff <= SRAM4_CNT_W'(AW_CYC - 1);
				SRAM4_WPUL: cnt_ff <= SRAM4_CNT_W'(WP_CYC - 1);
				SRAM4_WREC: cnt_ff <= SRAM4_CNT_W'(WR_CYC - 1);
				default:    cnt_ff <= '0;
			endcase
		end else if (!cnt_done) begin
			cnt_ff <= cnt_ff - 1'b1;
		end
	end

	// =========================================================================
	// Request capture
	// latch the 8-bit word select
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			addr_ff  <= '0;
			wdata_ff <= '0;
		end else if (take) begin
			addr_ff  <= req_addr_i;
			wdata_ff <= req_wdata_i;
		end
	end

	// =========================================================================
	// Pin bundle
	// select through every active phase
	assign pins_bus.sel   = (state_ff != SRAM4_IDLE);
	// strobe only in the pulse phase
	assign pins_bus.wr    = (state_ff == SRAM4_WPUL);
	assign pins_bus.rd    = (state_ff == SRAM4_RSET) | (state_ff == SRAM4_RACC);
	assign pins_bus.addr  = addr_ff;
	assign pins_bus.wdata = wdata_ff;

	sram4_pin_drv u_drv (
		.ref_clk_i             (ref_clk_i),
		.reset_i               (reset_i),
		.pins                  (pins_bus.drv),
		.word_select_lines_o   (word_select_lines_o),
		.write_data_lines_o    (write_data_lines_o),
		.select_low_active_n_o (select_low_active_n_o),
		.select_high_active_o  (select_high_active_o),
		.write_strobe_n_o      (write_strobe_n_o),
		.output_blank_o        (output_blank_o)
	);

	// =========================================================================
	// Read answer
	// Sampled at the end of the access phase; the device is static, so no
	// refresh slot ever delays it.
	// fixed latency, no refresh
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			rsp_valid_o <= 1'b0;
			rsp_rdata_o <= '0;
		end else begin
			rsp_valid_o <= (state_ff == SRAM4_RACC) & cnt_done;
			if ((state_ff == SRAM4_RACC) & cnt_done) begin
				rsp_rdata_o <= read_data_lines_i;
			end
		end
	end

	// =========================================================================
	// Checks
	sequence s_read_start;
		take && !req_write_i;
	endsequence

	sequence s_write_start;
		take && req_write_i;
	endsequence

	a_read_blank_low: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		(state_ff == SRAM4_RACC) |=> !output_blank_o)
		else $error("output blank not low during read access");

	// read answer after full access time
	// The answer flop is loaded at edge 2+ACC_CYC, so it is seen one edge later.
	a_read_latency: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		s_read_start |-> ##(3 + ACC_CYC) rsp_valid_o)
		else $error("read answer not at expected cycle");

	a_write_pulse: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		s_write_start |-> ##(2 + AW_CYC) (!write_strobe_n_o) [*8])
		else $error("write strobe pulse too short or late");

	a_write_setup: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		s_write_start |-> ##2 write_strobe_n_o [*8])
		else $error("write strobe asserted during address setup");

	a_enable_pair: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		select_low_active_n_o == !select_high_active_o)
		else $error("chip enables out of step");

	a_blank_on_write: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		!write_strobe_n_o |-> output_blank_o)
		else $error("outputs enabled while writing");

	a_idle_deselect: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		(state_ff == SRAM4_IDLE) && $past(state_ff == SRAM4_IDLE) |-> !select_high_active_o)
		else $error("device selected while idle");

	a_addr_stable: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		(state_ff != SRAM4_IDLE) && $past(state_ff != SRAM4_IDLE) |-> $stable(addr_ff))
		else $error("word select moved during access");

	a_rsp_cause: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		rsp_valid_o |-> $past(state_ff == SRAM4_RACC))
		else $error("answer without read access");

endmodule // sram4_host

// [verilog/sram4_pkg.sv]
// Package of constants and types shared by the static RAM host controller.
package sram4_pkg;

	// =========================================================================
	// Geometry
	localparam int unsigned SRAM4_WORDS      = 256;
	localparam int unsigned SRAM4_ADDR_W     = 8;
	localparam int unsigned SRAM4_DATA_W     = 4;

	// =========================================================================
	// Timing (nanoseconds, slowest grade) and derived cycle counts at 200 MHz
	localparam int unsigned SRAM4_CLK_PS     = 5000;
	localparam int unsigned SRAM4_T_ACC_NS   = 1000;
	localparam int unsigned SRAM4_T_AW_NS    = 150;
	localparam int unsigned SRAM4_T_WP_NS    = 750;
	localparam int unsigned SRAM4_T_WR_NS    = 100;
	localparam int unsigned SRAM4_ACC_CYC    = (SRAM4_T_ACC_NS * 1000 + SRAM4_CLK_PS - 1) / SRAM4_CLK_PS;
	localparam int unsigned SRAM4_AW_CYC     = (SRAM4_T_AW_NS * 1000 + SRAM4_CLK_PS - 1) / SRAM4_CLK_PS;
	localparam int unsigned SRAM4_WP_CYC     = (SRAM4_T_WP_NS * 1000 + SRAM4_CLK_PS - 1) / SRAM4_CLK_PS;
	localparam int unsigned SRAM4_WR_CYC     = (SRAM4_T_WR_NS * 1000 + SRAM4_CLK_PS - 1) / SRAM4_CLK_PS;
	localparam int unsigned SRAM4_CNT_W      = 8;

	// =========================================================================
	// Controller states
	typedef enum logic [2:0] {
		SRAM4_IDLE  = 3'b000,
		SRAM4_RSET  = 3'b001,
		SRAM4_RACC  = 3'b010,
		SRAM4_WSET  = 3'b011,
		SRAM4_WPUL  = 3'b100,
		SRAM4_WREC  = 3'b101
	} sram4_state_t;

endpackage

// [verilog/sram4_pins_if.sv]
// Interface carrying the memory pin bundle between sequencer and pin driver.
`timescale 1ns/1ps
interface sram4_pins_if;
	import sram4_pkg::*;
	logic [SRAM4_ADDR_W-1:0] addr;
	logic [SRAM4_DATA_W-1:0] wdata;
	logic                    sel;
	logic                    wr;
	logic                    rd;
	modport seq (output addr, output wdata, output sel, output wr, output rd);
	modport drv (input addr, input wdata, input sel, input wr, input rd);
endinterface

// [verilog/sram4_pin_drv.sv]
// Registered pin driver turning the abstract access bundle into device pin levels.
`timescale 1ns/1ps
module sram4_pin_drv
	import sram4_pkg::*;
(
	// Clock and reset.
	input  wire logic                    ref_clk_i,
	input  wire logic                    reset_i,
	// Abstract access from the sequencer.
	sram4_pins_if.drv                    pins,
	// Device pins.
	output logic [SRAM4_ADDR_W-1:0]      word_select_lines_o,
	output logic [SRAM4_DATA_W-1:0]      write_data_lines_o,
	output logic                         select_low_active_n_o,
	output logic                         select_high_active_o,
	output logic                         write_strobe_n_o,
	output logic                         output_blank_o
);

	// =========================================================================
	// Pin registers
	// All pins come from flops so no decode glitch ever reaches the device.
	// both enables together
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			select_low_active_n_o <= 1'b1;
			select_high_active_o  <= 1'b0;
			write_strobe_n_o      <= 1'b1;
			output_blank_o        <= 1'b1;
			word_select_lines_o   <= '0;
			write_data_lines_o    <= '0;
		end else begin
			select_low_active_n_o <= ~pins.sel;
			select_high_active_o  <= pins.sel;
			write_strobe_n_o      <= ~(pins.sel & pins.wr);
			output_blank_o        <= ~(pins.sel & pins.rd & ~pins.wr);
			word_select_lines_o   <= pins.addr;
			write_data_lines_o    <= pins.wdata;
		end
	end

	a_strobe_selected: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		!write_strobe_n_o |-> (!select_low_active_n_o && select_high_active_o))
		else $error("write strobe active while device deselected");

endmodule // sram4_pin_drv

// [sim/sram4_dev_model.sv]
// Behavioural model of the 256 x 4 static RAM as seen at its pins.
`timescale 1ns/1ps
module sram4_dev_model
	import sram4_pkg::*;
(
	// Device pins.
	input  wire logic [SRAM4_ADDR_W-1:0] word_select_lines_i,
	input  wire logic [SRAM4_DATA_W-1:0] write_data_lines_i,
	input  wire logic                    select_low_active_n_i,
	input  wire logic                    select_high_active_i,
	input  wire logic                    write_strobe_n_i,
	input  wire logic                    output_blank_i,
	output logic [SRAM4_DATA_W-1:0]      read_data_lines_o,
	// Model control and status.
	input  wire logic [15:0]             acc_ns_i,
	output logic [7:0]                   err_cnt_o
);
	logic [SRAM4_DATA_W-1:0] mem [SRAM4_WORDS];
	logic [SRAM4_ADDR_W-1:0] wr_addr;
	logic                    wr_on = 1'b0;
	realtime                 chg_t = 0;
	logic                    sel;
	initial err_cnt_o = 8'h00;
	assign sel = !select_low_active_n_i && select_high_active_i;
	// Any address, select, strobe or blank change restarts the access time.
	always @(word_select_lines_i, sel, write_strobe_n_i, output_blank_i) chg_t = $realtime;
	// level write; an address moving under the pulse is a host fault.
	always @(word_select_lines_i, write_data_lines_i, sel, write_strobe_n_i) begin
		if (sel && write_strobe_n_i === 1'b0) begin
			if (wr_on && word_select_lines_i !== wr_addr) err_cnt_o = err_cnt_o + 8'h01;
			mem[word_select_lines_i] = write_data_lines_i;
			wr_on = 1'b1;
			wr_addr = word_select_lines_i;
		end else wr_on = 1'b0;
	end
	// drive only when read is enabled and settled, else toggle off the clock edges.
	initial begin
		read_data_lines_o = 4'h5;
		#0.2;
		forever begin
			#1;
			if (sel && write_strobe_n_i && !output_blank_i && $realtime - chg_t >= acc_ns_i)
				read_data_lines_o = mem[word_select_lines_i];
			else read_data_lines_o = ~read_data_lines_o;
		end
	end
endmodule // sram4_dev_model

// [sim/sram4_host_bench.sv]
// Self-checking bench for the static RAM host controller.
`timescale 1ns/1ps
module sram4_host_bench;
	import sram4_pkg::*;
	// =========================================================================
	// Signals
	logic ref_clk_i, reset_i, req_valid_i, req_write_i, req_ready_o, rsp_valid_o;
	logic [7:0] req_addr_i, p_addr, err_cnt, ra;
	logic [3:0] req_wdata_i, rsp_rdata_o, p_wd, p_rd;
	logic p_ce_n, p_ce, p_we_n, p_ob, rdy_q;
	logic [15:0] acc_ns;
	logic [3:0] shadow [256];
	logic [255:0] known = '0;
	logic [31:0] rng = 32'h0000_105F; // Seed 4191.
	int miscompares = 0, check_count = 0, low_run = 0, n, i;

	sram4_host u_dut (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .req_valid_i(req_valid_i),
		.req_write_i(req_write_i), .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
		.req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o), .rsp_rdata_o(rsp_rdata_o),
		.word_select_lines_o(p_addr), .write_data_lines_o(p_wd), .select_low_active_n_o(p_ce_n),
		.select_high_active_o(p_ce), .write_strobe_n_o(p_we_n), .output_blank_o(p_ob),
		.read_data_lines_i(p_rd));
	sram4_dev_model u_mem (.word_select_lines_i(p_addr), .write_data_lines_i(p_wd),
		.select_low_active_n_i(p_ce_n), .select_high_active_i(p_ce), .write_strobe_n_i(p_we_n),
		.output_blank_i(p_ob), .read_data_lines_o(p_rd), .acc_ns_i(acc_ns), .err_cnt_o(err_cnt));

	// =========================================================================
	// Helpers
	function logic [31:0] rnd();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic summarize();
		$display("checks=%0d mismatches=%0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic tick();
		@(posedge ref_clk_i);
		#1;
	endtask
	// One request; a poke tries a write while busy, which must be ignored.
	task automatic access(input logic wr, input logic [7:0] a, input logic [3:0] d, input logic poke);
		n = 0;
		req_valid_i = 1'b1;
		req_write_i = wr;
		req_addr_i = a;
		req_wdata_i = d;
		while (req_ready_o !== 1'b1 && n < 300) begin
			tick();
			n++;
		end
		// A controller that never comes back to idle must not hang the run.
		if (n >= 300) begin
			miscompares++;
			summarize();
		end
		tick();
		req_valid_i = 1'b0;
		n = 0;
		while (n < 400 && (wr ? req_ready_o !== 1'b1 : rsp_valid_o !== 1'b1)) begin
			// The poke stands for exactly one edge; each signal changes once per step.
			if (poke && n == 9) begin
				req_valid_i = 1'b1;
				req_write_i = 1'b1;
				req_wdata_i = ~d;
			end else if (poke && n == 10) begin
				req_valid_i = 1'b0;
			end
			tick();
			n++;
		end
		if (req_valid_i) req_valid_i = 1'b0;
		if (n >= 400) begin
			miscompares++;
			summarize();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [3:0] d);
		access(1'b1, a, d, 1'b0);
		check(n, SRAM4_AW_CYC + SRAM4_WP_CYC + SRAM4_WR_CYC);
		shadow[a] = d;
		known[a] = 1'b1;
	endtask
	task automatic rd(input logic [7:0] a, input logic poke);
		access(1'b0, a, shadow[a], poke);
		check(n, 2 + SRAM4_ACC_CYC);
		check(rsp_rdata_o, shadow[a]);
	endtask

	// =========================================================================
	// Clock at 200 MHz.
	initial begin
		ref_clk_i = 1'b0;
		forever #2.5 ref_clk_i = ~ref_clk_i;
	end
	// Pin monitor: strobe width, levels during writes and reads, idle levels.
	always @(negedge ref_clk_i) begin
		if (reset_i) low_run = 0;
		else begin
			if (p_we_n === 1'b0) begin
				low_run++;
				check({p_ce_n, p_ce, p_ob}, 3'b011);
			end else if (low_run != 0) begin
				check(low_run >= SRAM4_WP_CYC, 1);
				low_run = 0;
			end
			if (p_ob === 1'b0) check({p_ce_n, p_ce, p_we_n}, 3'b011);
			if (rdy_q && req_ready_o) check({p_ce_n, p_ce, p_we_n, p_ob}, 4'b1011);
		end
		rdy_q = req_ready_o;
	end
	// Main sequence.
	initial begin
		reset_i = 1'b1;
		{req_valid_i, req_write_i, req_addr_i, req_wdata_i} = '0;
		acc_ns = 16'd50;
		rdy_q = 1'b0;
		repeat (20) @(posedge ref_clk_i);
		#1 reset_i = 1'b0;
		tick();
		check({p_ce_n, p_ce, p_we_n, p_ob, req_ready_o}, 5'b10111);
		wr(8'h00, 4'hA);
		wr(8'hFF, 4'h5);
		rd(8'hFF, 1'b0);
		acc_ns = 16'd990;
		rd(8'h00, 1'b1);
		rd(8'h00, 1'b0);
		$display("test corners done");
		for (i = 0; i < 40; i++) begin
			void'(rnd());
			acc_ns = rng[9] ? 16'd50 : 16'd990;
			ra = rng[7:0] & (rng[20] ? 8'h0F : 8'hFF);
			if (rng[8] && known[ra]) rd(ra, rng[10]);
			else wr(ra, rng[14:11]);
		end
		$display("test random done");
		req_valid_i = 1'b1;
		req_write_i = 1'b1;
		req_addr_i = 8'h42;
		tick();
		req_valid_i = 1'b0;
		repeat (100) tick();
		reset_i = 1'b1;
		repeat (2) tick();
		reset_i = 1'b0;
		tick();
		check({p_ce_n, p_ce, p_we_n, p_ob, req_ready_o}, 5'b10111);
		wr(8'h42, 4'hC);
		rd(8'h42, 1'b0);
		check(err_cnt, 8'h00);
		$display("test reset abort done");
		summarize();
	end
endmodule // sram4_host_bench
